//--- inc/dgob_defs.vh
// What this block does
// RQ1: Temperature code readable as low byte then high byte, both read-only.
// RQ2: New temperature conversion starts only when update bit goes zero to one.
// RQ3: Constant offset added only while offset enable bit is one.
// RQ4: Signed 16-bit offset, low and high byte, added to each sample.
// RQ5: Offset and gain held per channel; two-bit page field picks channel.
// RQ6: Signed 5-bit fractional offset in sixteenths of LSB added to I samples.
// RQ7: Unsigned gain multiplier from 0 to 4095/2048 in 1/2048 steps.
// RQ8: Gain is 12 bits: low eight in first register, upper four in second.
// RQ9: Leaving blanking, gain rises by the 12-bit up-step field each cycle; the code adds the field plus one.
// RQ10: Entering blanking, gain falls toward zero by the down-step field; the code subtracts the field plus one.
// RQ11: Read-only 2-bit blanking state code: blanked, down, up, data.
// RQ12: Software must write 0x01 to second datapath setup register before use.
// RQ13: Gain multiplication bypassed while gain stage enable is zero; resets to one.
// RQ14: Ramp stops exactly at target or zero; state then shows data or blanked.
// RQ15: Multi-byte settings are taken into the datapath as whole words.
`ifndef DGOB_DEFS_VH
`define DGOB_DEFS_VH

`define DGOB_A_PAGE 12'h008
`define DGOB_A_DPCTRL 12'h111
`define DGOB_A_TEMP_LO 12'h132
`define DGOB_A_TEMP_HI 12'h133
`define DGOB_A_TEMP_UPD 12'h134
`define DGOB_A_OFF_CTRL 12'h135
`define DGOB_A_OFF_LO 12'h136
`define DGOB_A_OFF_HI 12'h137
`define DGOB_A_FRAC 12'h13A
`define DGOB_A_GAIN_LO 12'h13C
`define DGOB_A_GAIN_HI 12'h13D
`define DGOB_A_UP_LO 12'h140
`define DGOB_A_UP_HI 12'h141
`define DGOB_A_DN_LO 12'h142
`define DGOB_A_DN_HI 12'h143
`define DGOB_A_SETUP2 12'h146
`define DGOB_A_BSTAT 12'h147

`define DGOB_GAIN_EN_BIT 5
`define DGOB_BSTAT_POS 6

`define DGOB_RST_PAGE 2'h3
`define DGOB_RST_GAIN 12'hAEA
`define DGOB_RST_GAIN_LO 8'hEA
`define DGOB_RST_UP_LO 8'h04
`define DGOB_RST_DN_LO 8'h09
`define DGOB_RST_UP 12'h004
`define DGOB_RST_DN 12'h009
`define DGOB_GAIN_UNITY 12'h800

`define DGOB_ST_BLANKED 2'h0
`define DGOB_ST_RAMP_DN 2'h1
`define DGOB_ST_RAMP_UP 2'h2
`define DGOB_ST_DATA 2'h3

`endif

//--- hw/dgob_fifo.v
`timescale 1ns/1ps
module dgob_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wptr_reg;
   reg [AW-1:0] rptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;

   assign in_ready = (count_reg != DEPTH);
   assign out_valid = (count_reg != 0);
   assign out_data = mem_reg[rptr_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge mclk) begin
      if (push) begin
         mem_reg[wptr_reg] <= in_data;
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         wptr_reg <= {AW{1'b0}};
         rptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wptr_reg <= (wptr_reg == DEPTH - 1) ? {AW{1'b0}} : wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= (rptr_reg == DEPTH - 1) ? {AW{1'b0}} : rptr_reg + 1'b1;
         end
         if (push & ~pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop & ~push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

//--- hw/dgob_path.v
`timescale 1ns/1ps
`include "dgob_defs.vh"
module dgob_path #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Register port, byte wide
   input wire [11:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Incoming samples, I in [15:0], Q in [31:16]
   input wire s_valid,
   output wire s_ready,
   input wire [31:0] s_data,
   // Conditioned samples to the converters
   output reg m_valid,
   input wire m_ready,
   output reg [31:0] m_data,
   // Blanking requests per channel, asynchronous pins
   input wire [1:0] blank_req,
   // Auxiliary converter for the temperature code
   output reg temp_conv_start,
   input wire temp_conv_done,
   input wire [15:0] temp_code
);
   reg [1:0] page_reg;
   reg gain_en_reg;
   reg temp_upd_reg;
   reg [15:0] temp_reg;
   reg off_en_reg;
   reg [7:0] setup2_reg;
   reg [7:0] rdata_next;

   wire [15:0] off_w [0:1];
   wire [7:0] off_lo_w [0:1];
   wire [4:0] frac_w [0:1];
   wire [7:0] gain_lo_w [0:1];
   wire [11:0] gain_w [0:1];
   wire [7:0] up_lo_w [0:1];
   wire [11:0] up_w [0:1];
   wire [7:0] dn_lo_w [0:1];
   wire [11:0] dn_w [0:1];
   wire [1:0] st_w [0:1];
   wire [31:0] result_w;

   wire fifo_valid;
   wire fifo_ready;
   wire [31:0] fifo_data;
   wire rsel;

   // Samples queue here while the converter side stalls
   dgob_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .in_valid(s_valid),
      .in_ready(s_ready),
      .in_data(s_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   assign fifo_ready = ~m_valid | m_ready;

   always @(posedge mclk) begin
      if (reset) begin
         m_valid <= 1'b0;
         m_data <= 32'h00000000;
      end else if (fifo_ready) begin
         m_valid <= fifo_valid;
         if (fifo_valid) begin
            m_data <= result_w;
         end
      end
   end

   // Shared control registers and temperature readback
   always @(posedge mclk) begin
      if (reset) begin
         page_reg <= `DGOB_RST_PAGE;
         gain_en_reg <= 1'b1;
         temp_upd_reg <= 1'b0;
         temp_reg <= 16'h0000;
         off_en_reg <= 1'b0;
         setup2_reg <= 8'h00;
         temp_conv_start <= 1'b0;
      end else begin
         temp_conv_start <= 1'b0;
         if (temp_conv_done) begin
            temp_reg <= temp_code; // [RQ1]
         end
         if (reg_wr) begin
            case (reg_addr)
               `DGOB_A_PAGE: begin
                  page_reg <= reg_wdata[1:0];
               end
               `DGOB_A_DPCTRL: begin
                  gain_en_reg <= reg_wdata[`DGOB_GAIN_EN_BIT]; // [RQ13]
               end
               `DGOB_A_TEMP_UPD: begin
                  temp_upd_reg <= reg_wdata[0];
                  // A one over a one starts nothing
                  temp_conv_start <= reg_wdata[0] & ~temp_upd_reg; // [RQ2]
               end
               `DGOB_A_OFF_CTRL: begin
                  off_en_reg <= reg_wdata[0];
               end
               `DGOB_A_SETUP2: begin
                  setup2_reg <= reg_wdata; // [RQ12]
               end
               default: begin
               end
            endcase
         end
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : ch_g
         reg [7:0] off_lo_reg;
         reg [15:0] off_reg;
         reg [4:0] frac_reg;
         reg [7:0] gain_lo_reg;
         reg [11:0] gain_reg;
         reg [7:0] up_lo_reg;
         reg [11:0] up_reg;
         reg [7:0] dn_lo_reg;
         reg [11:0] dn_reg;
         reg [11:0] cur_reg;
         reg [11:0] cur_next;
         reg [1:0] st_reg;
         reg [1:0] st_next;
         reg sync1_reg;
         reg sync2_reg;
         wire wr_ch;
         wire [11:0] target;
         wire [12:0] up_sum;
         wire [12:0] dn_amt;
         wire [15:0] samp;
         wire signed [28:0] prod;
         wire [31:0] offx;
         wire [31:0] fracx;
         wire [31:0] sum;
         wire [20:0] sh;
         wire ovf;

         assign wr_ch = reg_wr & page_reg[ch]; // [RQ5]
         assign off_w[ch] = off_reg;
         assign off_lo_w[ch] = off_lo_reg;
         assign frac_w[ch] = frac_reg;
         assign gain_lo_w[ch] = gain_lo_reg;
         assign gain_w[ch] = gain_reg;
         assign up_lo_w[ch] = up_lo_reg;
         assign up_w[ch] = up_reg;
         assign dn_lo_w[ch] = dn_lo_reg;
         assign dn_w[ch] = dn_reg;
         assign st_w[ch] = st_reg;

         // Low bytes wait in staging; the high byte commits the whole word
         always @(posedge mclk) begin
            if (reset) begin
               off_lo_reg <= 8'h00;
               off_reg <= 16'h0000;
               frac_reg <= 5'h00;
               gain_lo_reg <= `DGOB_RST_GAIN_LO;
               gain_reg <= `DGOB_RST_GAIN;
               up_lo_reg <= `DGOB_RST_UP_LO;
               up_reg <= `DGOB_RST_UP;
               dn_lo_reg <= `DGOB_RST_DN_LO;
               dn_reg <= `DGOB_RST_DN;
            end else if (wr_ch) begin
               case (reg_addr)
                  `DGOB_A_OFF_LO: off_lo_reg <= reg_wdata;
                  `DGOB_A_OFF_HI: off_reg <= {reg_wdata, off_lo_reg}; // [RQ4] [RQ15]
                  `DGOB_A_FRAC: frac_reg <= reg_wdata[4:0];
                  `DGOB_A_GAIN_LO: gain_lo_reg <= reg_wdata;
                  `DGOB_A_GAIN_HI: gain_reg <= {reg_wdata[3:0], gain_lo_reg}; // [RQ8] [RQ15]
                  `DGOB_A_UP_LO: up_lo_reg <= reg_wdata;
                  `DGOB_A_UP_HI: up_reg <= {reg_wdata[3:0], up_lo_reg}; // [RQ15]
                  `DGOB_A_DN_LO: dn_lo_reg <= reg_wdata;
                  `DGOB_A_DN_HI: dn_reg <= {reg_wdata[3:0], dn_lo_reg}; // [RQ15]
                  default: begin
                  end
               endcase
            end
         end

         always @(posedge mclk) begin
            sync1_reg <= blank_req[ch];
            sync2_reg <= sync1_reg;
         end

         // Gain stage off means unity, so blanking still ramps
         assign target = gain_en_reg ? gain_reg : `DGOB_GAIN_UNITY; // [RQ13]
         // Step field zero still moves by one
         assign up_sum = {1'b0, cur_reg} + {1'b0, up_reg} + 13'h0001; // [RQ9]
         assign dn_amt = {1'b0, dn_reg} + 13'h0001; // [RQ10]

         always @* begin
            cur_next = cur_reg;
            st_next = st_reg;
            case (st_reg)
               `DGOB_ST_BLANKED: begin
                  cur_next = 12'h000;
                  if (~sync2_reg) begin
                     st_next = `DGOB_ST_RAMP_UP;
                  end
               end
               `DGOB_ST_RAMP_UP: begin
                  if (sync2_reg) begin
                     st_next = `DGOB_ST_RAMP_DN;
                  end else if (up_sum >= {1'b0, target}) begin
                     cur_next = target; // [RQ14]
                     st_next = `DGOB_ST_DATA;
                  end else begin
                     cur_next = up_sum[11:0]; // [RQ9]
                  end
               end
               `DGOB_ST_RAMP_DN: begin
                  if (~sync2_reg) begin
                     st_next = `DGOB_ST_RAMP_UP;
                  end else if ({1'b0, cur_reg} <= dn_amt) begin
                     cur_next = 12'h000; // [RQ14]
                     st_next = `DGOB_ST_BLANKED;
                  end else begin
                     cur_next = cur_reg - dn_amt[11:0]; // [RQ10]
                  end
               end
               `DGOB_ST_DATA: begin
                  cur_next = target;
                  if (sync2_reg) begin
                     st_next = `DGOB_ST_RAMP_DN;
                  end
               end
               default: begin
                  cur_next = 12'h000;
                  st_next = `DGOB_ST_BLANKED;
               end
            endcase
         end

         always @(posedge mclk) begin
            if (reset) begin
               cur_reg <= 12'h000;
               st_reg <= `DGOB_ST_BLANKED;
            end else begin
               cur_reg <= cur_next;
               st_reg <= st_next;
            end
         end

         // Full precision sum, then one truncation and saturation
         assign samp = fifo_data[ch*16 +: 16];
         assign prod = $signed(samp) * $signed({1'b0, cur_reg}); // [RQ7]
         assign offx = off_en_reg ? {{5{off_reg[15]}}, off_reg, 11'h000} : 32'h00000000; // [RQ3] [RQ4]
         if (ch == 0) begin : frac_g
            assign fracx = off_en_reg ? {{20{frac_reg[4]}}, frac_reg, 7'h00} : 32'h00000000; // [RQ6]
         end else begin : nofrac_g
            assign fracx = 32'h00000000;
         end
         assign sum = {{3{prod[28]}}, prod} + offx + fracx;
         assign sh = sum[31:11];
         assign ovf = (sh[20:15] != {6{sh[20]}});
         assign result_w[ch*16 +: 16] = ovf ? (sh[20] ? 16'h8000 : 16'h7FFF) : sh[15:0];
      end
   endgenerate

   // Readback shows the lowest selected page
   assign rsel = ~page_reg[0];

   always @* begin
      rdata_next = 8'h00;
      case (reg_addr)
         `DGOB_A_PAGE: rdata_next = {6'h00, page_reg};
         `DGOB_A_DPCTRL: rdata_next = {2'h0, gain_en_reg, 5'h00};
         `DGOB_A_TEMP_LO: rdata_next = temp_reg[7:0]; // [RQ1]
         `DGOB_A_TEMP_HI: rdata_next = temp_reg[15:8]; // [RQ1]
         `DGOB_A_TEMP_UPD: rdata_next = {7'h00, temp_upd_reg};
         `DGOB_A_OFF_CTRL: rdata_next = {7'h00, off_en_reg};
         `DGOB_A_OFF_LO: rdata_next = off_lo_w[rsel];
         `DGOB_A_OFF_HI: rdata_next = off_w[rsel][15:8];
         `DGOB_A_FRAC: rdata_next = {3'h0, frac_w[rsel]};
         `DGOB_A_GAIN_LO: rdata_next = gain_lo_w[rsel];
         `DGOB_A_GAIN_HI: rdata_next = {4'h0, gain_w[rsel][11:8]};
         `DGOB_A_UP_LO: rdata_next = up_lo_w[rsel];
         `DGOB_A_UP_HI: rdata_next = {4'h0, up_w[rsel][11:8]};
         `DGOB_A_DN_LO: rdata_next = dn_lo_w[rsel];
         `DGOB_A_DN_HI: rdata_next = {4'h0, dn_w[rsel][11:8]};
         `DGOB_A_SETUP2: rdata_next = setup2_reg;
         `DGOB_A_BSTAT: rdata_next = {st_w[rsel], 6'h00}; // [RQ11]
         default: rdata_next = 8'h00;
      endcase
   end

   always @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end
endmodule

//--- tb/dgob_path_monitor.sv
`timescale 1ns/1ps
module dgob_path_monitor (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Register port
   input wire [11:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // Sample streams
   input wire s_valid,
   input wire s_ready,
   input wire [31:0] s_data,
   input wire m_valid,
   input wire m_ready,
   input wire [31:0] m_data,
   // Blanking and temperature
   input wire [1:0] blank_req,
   input wire temp_conv_start,
   input wire temp_conv_done,
   input wire [15:0] temp_code
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   wire upd_wr = reg_wr && reg_addr == 12'h134 && reg_wdata[0];
   wire t_rd = reg_rd && (reg_addr == 12'h132 || reg_addr == 12'h133);
   reg [15:0] code_q;
   reg [7:0] code_rd;
   reg [7:0] rmask;
   reg off_en;
   reg upd_bit;
   reg [12:0] bcnt;
   // Longest legal fall is 4095 steps of one, so wait past it
   always @(posedge mclk) begin
      if (reset) begin
         code_q <= 16'h0000;
         off_en <= 1'b0;
         upd_bit <= 1'b0;
         bcnt <= 13'h0000;
      end else begin
         if (reg_wr && reg_addr == 12'h134)
            upd_bit <= reg_wdata[0];
         if (temp_conv_done)
            code_q <= temp_code;
         if (reg_wr && reg_addr == 12'h135)
            off_en <= reg_wdata[0];
         if (blank_req != 2'h3)
            bcnt <= 13'h0000;
         else if (bcnt != 13'h1100)
            bcnt <= bcnt + 13'h0001;
      end
   end
   always @(posedge mclk) begin
      code_rd <= reg_addr[0] ? code_q[15:8] : code_q[7:0];
      case (reg_addr)
         12'h134, 12'h135: rmask <= 8'hFE;
         12'h13A: rmask <= 8'hE0;
         12'h13D, 12'h141, 12'h143: rmask <= 8'hF0;
         12'h147: rmask <= 8'h3F;
         12'h138, 12'h145: rmask <= 8'hFF;
         default: rmask <= 8'h00;
      endcase
   end
   chk_start_single: assert property (temp_conv_start |=> !temp_conv_start)
      else $error("start pulse too long");
   chk_start_cause: assert property (temp_conv_start |-> $past(upd_wr))
      else $error("start without update write");
   chk_no_rearm: assert property (upd_wr && upd_bit |=> !temp_conv_start)
      else $error("start while bit already set");
   chk_temp_read: assert property (t_rd && !temp_conv_done |=> reg_rdata == code_rd)
      else $error("temperature byte wrong");
   chk_resv_zero: assert property (reg_rd |=> (reg_rdata & rmask) == 8'h00)
      else $error("reserved bits not zero");
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
   chk_out_hold: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data))
      else $error("output changed under stall");
   chk_blank_zero: assert property (m_valid && bcnt == 13'h1100 && !off_en |-> m_data == 32'h0)
      else $error("blanked output not zero");
   cover property (temp_conv_start);
   cover property (m_valid && !m_ready);
   cover property (m_valid && bcnt == 13'h1100);
endmodule
bind dgob_path dgob_path_monitor mon (
   .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .s_valid(s_valid), .s_ready(s_ready),
   .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data),
   .blank_req(blank_req), .temp_conv_start(temp_conv_start),
   .temp_conv_done(temp_conv_done), .temp_code(temp_code)
);

//--- tb/dgob_src.sv
`timescale 1ns/1ps
module dgob_src (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Sample stream
   output reg s_valid,
   input wire s_ready,
   output reg [31:0] s_data,
   // Auxiliary converter
   input wire temp_conv_start,
   output reg temp_conv_done,
   output reg [15:0] temp_code
);
   reg [15:0] code;
   reg [3:0] cnt;
   initial begin
      s_valid = 1'b0;
      s_data = 32'h0;
      temp_conv_done = 1'b0;
      temp_code = 16'h0;
   end
   // Both lanes step by one per word; gap gives a slow source
   task send(input [31:0] base, input integer n, input integer gap);
      integer k, w;
      begin
         for (k = 0; k < n; k = k + 1) begin
            s_valid <= 1'b1;
            s_data <= base + k * 32'h00010001;
            w = 0;
            @(posedge mclk);
            while (!s_ready && w < 100) begin
               w = w + 1;
               @(posedge mclk);
            end
            if (gap != 0 || k == n - 1) begin
               s_valid <= 1'b0;
               s_data <= ~s_data;
            end
            if (gap != 0 && k < n - 1)
               @(posedge mclk);
         end
      end
   endtask
   // Code bus toggles outside the done pulse
   always @(posedge mclk) begin
      temp_conv_done <= 1'b0;
      temp_code <= ~temp_code;
      if (reset) begin
         cnt <= 4'h0;
         code <= 16'h5A01;
      end else if (temp_conv_start)
         cnt <= 4'h6;
      else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h1) begin
            temp_conv_done <= 1'b1;
            temp_code <= code;
            code <= code + 16'h2345;
         end
      end
   end
endmodule

//--- tb/dgob_path_tb.sv
`timescale 1ns/1ps
module dgob_path_tb;
   reg mclk = 1'b0;
   reg reset = 1'b1;
   reg [11:0] reg_addr = 12'h000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [7:0] reg_wdata = 8'h00;
   reg m_ready = 1'b1;
   reg [1:0] blank_req = 2'h0;
   wire [7:0] reg_rdata;
   wire s_valid, s_ready, m_valid, temp_conv_start, temp_conv_done;
   wire [31:0] s_data, m_data;
   wire [15:0] temp_code;
   integer err_count = 0;
   integer n_compared = 0;
   integer k;
   always #12.5 mclk = ~mclk;
   dgob_path dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .s_valid(s_valid),
      .s_ready(s_ready), .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready),
      .m_data(m_data), .blank_req(blank_req), .temp_conv_start(temp_conv_start),
      .temp_conv_done(temp_conv_done), .temp_code(temp_code));
   dgob_src src (.mclk(mclk), .reset(reset), .s_valid(s_valid), .s_ready(s_ready),
      .s_data(s_data), .temp_conv_start(temp_conv_start),
      .temp_conv_done(temp_conv_done), .temp_code(temp_code));
   task stop_test;
      begin
         if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task tmo;
      begin
         err_count = err_count + 1;
         $display("wrong value at %0t: no answer", $time);
         stop_test;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [11:0] a, input [7:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge mclk);
         reg_wr <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task rdc(input [11:0] a, input [7:0] e);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge mclk);
         reg_rd <= 1'b0;
         @(posedge mclk);
         cmp({24'h0, reg_rdata}, {24'h0, e});
      end
   endtask
   task get(input [31:0] exp);
      integer w;
      begin
         w = 0;
         @(posedge mclk);
         while (!(m_valid && m_ready) && w < 300) begin
            w = w + 1;
            @(posedge mclk);
         end
         if (w == 300)
            tmo;
         cmp(m_data, exp);
      end
   endtask
   task wt_done;
      integer w;
      begin
         w = 0;
         while (temp_conv_done !== 1'b1 && w < 40) begin
            w = w + 1;
            @(posedge mclk);
         end
         if (w == 40)
            tmo;
      end
   endtask
   // Polls the state code until fin, noting whether mid was passed
   task wait_st(input [1:0] fin, input [1:0] mid);
      integer w;
      reg seen;
      reg got_fin;
      begin
         seen = 1'b0;
         got_fin = 1'b0;
         w = 0;
         // Read first: the held read data may belong to another register
         while (!got_fin && w < 600) begin
            reg_addr <= 12'h147;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            @(posedge mclk);
            if (reg_rdata[7:6] === mid)
               seen = 1'b1;
            if (reg_rdata[7:6] === fin)
               got_fin = 1'b1;
            w = w + 1;
         end
         if (!got_fin)
            tmo;
         cmp({31'h0, seen}, 32'h1);
      end
   endtask
   task t_regs;
      begin
         rdc(12'h134, 8'h00);
         rdc(12'h135, 8'h00);
         rdc(12'h137, 8'h00);
         rdc(12'h13A, 8'h00);
         rdc(12'h13C, 8'hEA);
         rdc(12'h13D, 8'h0A);
         rdc(12'h140, 8'h04);
         rdc(12'h142, 8'h09);
         rdc(12'h111, 8'h20);
         rdc(12'h145, 8'h00);
         wr(12'h146, 8'h01);
         rdc(12'h146, 8'h01);
      end
   endtask
   task t_temp;
      begin
         wr(12'h134, 8'h01);
         wt_done;
         rdc(12'h132, 8'h01);
         rdc(12'h133, 8'h5A);
         wr(12'h134, 8'h01);
         repeat (12) @(posedge mclk);
         wr(12'h134, 8'h00);
         wr(12'h134, 8'h01);
         wt_done;
         wr(12'h133, 8'hFF);
         rdc(12'h133, 8'h7D);
      end
   endtask
   task t_gain;
      begin
         wr(12'h140, 8'h1F);
         wr(12'h142, 8'h1F);
         wait_st(2'h3, 2'h2);
         wr(12'h13C, 8'hFF);
         wr(12'h13D, 8'h0F);
         src.send(32'h70001000, 1, 0);
         get(32'h7FFF1FFE);
         wr(12'h13C, 8'h00);
         src.send(32'h70001000, 1, 0);
         get(32'h7FFF1FFE);
         wr(12'h13D, 8'h08);
         wr(12'h135, 8'h01);
         wr(12'h136, 8'hFE);
         wr(12'h137, 8'hFF);
         wr(12'h13A, 8'h18);
         src.send(32'h00640064, 1, 0);
         get(32'h00620061);
         wr(12'h135, 8'h00);
         wr(12'h13D, 8'h04);
         src.send(32'h00640064, 1, 0);
         get(32'h00320032);
         wr(12'h111, 8'h00);
         src.send(32'h00640064, 1, 0);
         get(32'h00640064);
         wr(12'h111, 8'h20);
         wr(12'h008, 8'h02);
         rdc(12'h13D, 8'h04);
         wr(12'h13D, 8'h08);
         wr(12'h008, 8'h01);
         src.send(32'h00640064, 1, 1);
         get(32'h00640032);
         wr(12'h13D, 8'h08);
         wr(12'h008, 8'h03);
      end
   endtask
   task t_fifo;
      begin
         m_ready <= 1'b0;
         src.send(32'h00100010, 9, 0);
         @(posedge mclk);
         cmp({31'h0, s_ready}, 32'h0);
         m_ready <= 1'b1;
         for (k = 0; k < 9; k = k + 1)
            get(32'h00100010 + k * 32'h00010001);
         @(posedge mclk);
         cmp({30'h0, m_valid, s_ready}, 32'h1);
      end
   endtask
   task t_blank;
      begin
         blank_req <= 2'h1;
         wait_st(2'h0, 2'h1);
         // Stall the output so neither word leaves before get looks
         m_ready <= 1'b0;
         src.send(32'h00640064, 2, 1);
         m_ready <= 1'b1;
         get(32'h00640000);
         get(32'h00650000);
         blank_req <= 2'h0;
         wait_st(2'h3, 2'h2);
         src.send(32'h00640064, 1, 0);
         get(32'h00640064);
         blank_req <= 2'h3;
         repeat (4400) @(posedge mclk);
         src.send(32'h12341234, 1, 0);
         get(32'h00000000);
      end
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      t_regs;
      t_temp;
      t_gain;
      t_fifo;
      t_blank;
      stop_test;
   end
endmodule
